// ===== shared/strap_pkg.sv
// Notes on behaviour
// (RULE_01) Strap pins are inputs while hard reset.
// (RULE_02) Capture strap levels at hard reset release.
// (RULE_03) After capture, receiver off, pad drives normally.
// (RULE_04) Pull-up on during reset and few clocks.
// (RULE_05) Pull-up disabled together with input receiver.
// (RULE_06) High strap level selects default bit setting.
// (RULE_07) Board drives clock-ratio straps; no pull-up there.
// (RULE_08) Board must not pull down listed pins.
// (RULE_09) System holds async control inputs deasserted.
// (RULE_10) System asserts test reset during reset.
// (RULE_11) TAP resets through TCK and TMS alone.
// (RULE_12) Probe asserts resets independently; others merged.
// (RULE_13) Without debugger, tie test reset to reset.
// (RULE_14) Soft reset raises machine-check, not full reset.
// (RULE_15) Post-release enable window is parameter, default four.
`default_nettype none
package strap_pkg;
	localparam int STRAP_WIDTH = 8;
	localparam int HOLD_CYCLES = 4;
	localparam int HOLD_CNT_W = 4;
	localparam int TAP_RESET_TMS_ONES = 5;
	localparam logic [STRAP_WIDTH-1:0] STRAP_RESET_VALUE = 8'hff;
	localparam logic [STRAP_WIDTH-1:0] STRAP_PULLUP_MASK = 8'hfc;
	typedef enum logic [1:0] {ST_RESET, ST_HOLD, ST_RUN} strap_state_t;
endpackage
`default_nettype wire

// ===== hw/tap_reset_detect.sv
`timescale 1ns/10ps
`default_nettype none
module tap_reset_detect
	import strap_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tck_rise,
	input wire logic tms,
	output logic tap_reset
);
	logic [2:0] ones_q;

	// Five rising TCK edges with TMS high reach the reset state from any state.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ones_q <= 3'h0;
		end else if (tck_rise) begin
			if (!tms) begin
				ones_q <= 3'h0;
			end else if (ones_q != 3'(TAP_RESET_TMS_ONES)) begin
				ones_q <= ones_q + 3'h1; // RULE_11
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tap_reset <= 1'b1;
		end else begin
			tap_reset <= (ones_q == 3'(TAP_RESET_TMS_ONES)); // RULE_11
		end
	end

	property p_tap_hold;
		@(posedge clk) disable iff (rst) (tck_rise && !tms) |=> ##1 !tap_reset;
	endproperty
	a_tap_hold: assert property (p_tap_hold) else $error("TAP reset did not drop after TMS low."); // RULE_11
endmodule
`default_nettype wire

// ===== hw/strap_latch.sv
`timescale 1ns/10ps
`default_nettype none
module strap_latch
	import strap_pkg::*;
#(
	parameter int HOLD = HOLD_CYCLES
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic HARD_RESET_IN_N,
	input wire logic SOFT_RESET_IN_N,
	input wire logic TEST_RESET_IN_N,
	input wire logic TCK,
	input wire logic TMS,
	input wire logic [strap_pkg::STRAP_WIDTH-1:0] STRAP_PIN_IN,
	input wire logic [strap_pkg::STRAP_WIDTH-1:0] FUNC_OUT,
	input wire logic [strap_pkg::STRAP_WIDTH-1:0] FUNC_OE,
	output logic [strap_pkg::STRAP_WIDTH-1:0] STRAP_PIN_OUT,
	output logic [strap_pkg::STRAP_WIDTH-1:0] STRAP_PIN_OE,
	output logic [strap_pkg::STRAP_WIDTH-1:0] PULLUP_EN,
	output logic RECEIVER_EN,
	output logic [strap_pkg::STRAP_WIDTH-1:0] CONFIG_OUT,
	output logic CONFIG_VALID,
	output logic MACHINE_CHECK,
	output logic TAP_RESET
);
	import strap_pkg::*;

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	logic [STRAP_WIDTH-1:0] strap_s1_q, strap_s2_q;
	logic [3:0] ctl_s1_q, ctl_s2_q;
	logic tck_prev_q;
	logic hard_rst, soft_rst, test_rst, tck_s, tms_s;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			strap_s1_q <= STRAP_RESET_VALUE;
			strap_s2_q <= STRAP_RESET_VALUE;
			// Reset values match the idle pins, so no false TCK edge follows reset.
			ctl_s1_q <= 4'h3;
			ctl_s2_q <= 4'h3;
		end else begin
			strap_s1_q <= STRAP_PIN_IN;
			strap_s2_q <= strap_s1_q;
			ctl_s1_q <= {TMS, TCK, TEST_RESET_IN_N, SOFT_RESET_IN_N};
			ctl_s2_q <= ctl_s1_q;
		end
	end

	// Test reset is level sensitive, soft reset and TCK edge sensitive; glitches on them are the board's concern.
	assign soft_rst = !ctl_s2_q[0]; // RULE_09
	assign test_rst = !ctl_s2_q[1]; // RULE_10
	assign tck_s = ctl_s2_q[2];
	assign tms_s = ctl_s2_q[3];

	// Hard reset gets its own pair so that the state machine sees a clean level.
	logic hr_s1_q, hr_s2_q;
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			hr_s1_q <= 1'b1;
			hr_s2_q <= 1'b1;
		end else begin
			hr_s1_q <= !HARD_RESET_IN_N;
			hr_s2_q <= hr_s1_q;
		end
	end
	assign hard_rst = hr_s2_q;

	// ==========================================================
	// Capture sequence
	// ==========================================================
	strap_state_t state_q;
	logic [HOLD_CNT_W-1:0] hold_q;
	logic [STRAP_WIDTH-1:0] config_q;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state_q <= ST_RESET;
		end else if (hard_rst) begin
			state_q <= ST_RESET;
		end else begin
			unique case (state_q)
				ST_RESET: begin
					state_q <= ST_HOLD;
				end
				ST_HOLD: begin
					if (hold_q == HOLD_CNT_W'(HOLD - 1)) begin
						state_q <= ST_RUN; // RULE_15
					end
				end
				ST_RUN: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			hold_q <= '0;
		end else if (state_q != ST_HOLD) begin
			hold_q <= '0;
		end else begin
			hold_q <= hold_q + HOLD_CNT_W'(1); // RULE_15
		end
	end

	// The value latched is the one present as reset lets go; a high bit means default.
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			config_q <= STRAP_RESET_VALUE; // RULE_06
		end else if (state_q == ST_RESET && !hard_rst) begin
			config_q <= strap_s2_q; // RULE_02
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			CONFIG_VALID <= 1'b0;
		end else begin
			CONFIG_VALID <= (state_q != ST_RESET) && !hard_rst;
		end
	end
	assign CONFIG_OUT = config_q;

	// ==========================================================
	// Pad control
	// ==========================================================
	logic in_window;
	// The synchronised pin opens the window as well, so a pad stops driving as soon as
	// hard reset is seen instead of one cycle later when the state has caught up.
	assign in_window = (state_q != ST_RUN) || hard_rst; // RULE_01

	// Receiver and pull-up share one enable so they always drop together.
	assign RECEIVER_EN = in_window; // RULE_03 RULE_05
	assign PULLUP_EN = in_window ? STRAP_PULLUP_MASK : '0; // RULE_04 RULE_07
	assign STRAP_PIN_OE = in_window ? '0 : FUNC_OE; // RULE_01 RULE_03
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			STRAP_PIN_OUT <= '0;
		end else begin
			STRAP_PIN_OUT <= FUNC_OUT;
		end
	end

	// ==========================================================
	// Soft reset and test access reset
	// ==========================================================
	logic soft_prev_q;
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			soft_prev_q <= 1'b0;
			tck_prev_q <= 1'b0;
			MACHINE_CHECK <= 1'b0;
		end else begin
			soft_prev_q <= soft_rst;
			tck_prev_q <= tck_s;
			// A pulse on assertion only; soft reset never reaches the capture logic.
			MACHINE_CHECK <= soft_rst && !soft_prev_q && !hard_rst; // RULE_14
		end
	end

	logic tap_seq_reset;
	tap_reset_detect u_tap (
		.clk(CLOCK),
		.rst(RST),
		.tck_rise(tck_s && !tck_prev_q),
		.tms(tms_s),
		.tap_reset(tap_seq_reset)
	);
	// Test reset stays separate from hard reset so the probe can drive each.
	assign TAP_RESET = test_rst || tap_seq_reset; // RULE_11 RULE_12 RULE_13

	// ==========================================================
	// Checks
	// ==========================================================
	property p_input_in_reset;
		@(posedge CLOCK) disable iff (RST) hard_rst |-> (STRAP_PIN_OE == '0) && RECEIVER_EN;
	endproperty
	a_input_in_reset: assert property (p_input_in_reset) else $error("Strap pad driven in reset."); // RULE_01

	property p_capture;
		@(posedge CLOCK) disable iff (RST)
		($past(hard_rst) && !hard_rst) |=> (config_q == $past(strap_s2_q));
	endproperty
	a_capture: assert property (p_capture) else $error("Strap value not captured."); // RULE_02

	property p_release;
		@(posedge CLOCK) disable iff (RST) $fell(hard_rst) |-> ##[4:20] !RECEIVER_EN;
	endproperty
	a_release: assert property (p_release) else $error("Receiver not released."); // RULE_03

	property p_pullup_window;
		@(posedge CLOCK) disable iff (RST) $fell(hard_rst) |-> (PULLUP_EN != '0) [*4];
	endproperty
	a_pullup_window: assert property (p_pullup_window) else $error("Pull-up dropped early."); // RULE_04

	property p_pullup_with_rx;
		@(posedge CLOCK) disable iff (RST) (PULLUP_EN != '0) == RECEIVER_EN;
	endproperty
	a_pullup_with_rx: assert property (p_pullup_with_rx) else $error("Pull-up and receiver differ."); // RULE_05

	property p_default_high;
		@(posedge CLOCK) disable iff (RST)
		hard_rst ##1 (!hard_rst && strap_s2_q == '1) |=> config_q == STRAP_RESET_VALUE;
	endproperty
	a_default_high: assert property (p_default_high) else $error("Default not selected."); // RULE_06

	property p_mcheck;
		@(posedge CLOCK) disable iff (RST) MACHINE_CHECK |-> !hard_rst && !$changed(config_q);
	endproperty
	a_mcheck: assert property (p_mcheck) else $error("Soft reset disturbed state."); // RULE_14

	property p_mcheck_pulse;
		@(posedge CLOCK) disable iff (RST) MACHINE_CHECK |=> !MACHINE_CHECK;
	endproperty
	a_mcheck_pulse: assert property (p_mcheck_pulse) else $error("Machine check held too long."); // RULE_14

	property p_hold_len;
		@(posedge CLOCK) disable iff (RST) (state_q == ST_HOLD) |-> hold_q < HOLD_CNT_W'(HOLD);
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("Hold window overrun."); // RULE_15
endmodule
`default_nettype wire

// ===== tb/reset_board_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Board reset sources, debug probe and strap resistors.
module reset_board_model
	import strap_pkg::*;
(
	input wire logic probe_hard_n,
	input wire logic board_hard_n,
	input wire logic probe_test_n,
	input wire logic tie_test,
	input wire logic [strap_pkg::STRAP_WIDTH-1:0] pull_down,
	input wire logic [1:0] ratio,
	input wire logic [strap_pkg::STRAP_WIDTH-1:0] pin_out,
	input wire logic [strap_pkg::STRAP_WIDTH-1:0] pin_oe,
	input wire logic [strap_pkg::STRAP_WIDTH-1:0] pullup_en,
	output logic hard_n,
	output logic test_n,
	output logic [strap_pkg::STRAP_WIDTH-1:0] pad
);
	assign hard_n = probe_hard_n & board_hard_n;
	assign test_n = probe_test_n & (tie_test ? hard_n : 1'b1);
	// A pad nobody drives reads the ratio on bits 1:0, low if pulled down, high under the pull-up, else the inverse of its pin_out bit.
	always_comb begin
		for (int i = 0; i < STRAP_WIDTH; i++) begin
			if (pin_oe[i]) pad[i] = pin_out[i];
			else if (i < 2) pad[i] = ratio[i[0]];
			else if (pull_down[i]) pad[i] = 1'b0;
			else pad[i] = pullup_en[i] ? 1'b1 : ~pin_out[i];
		end
	end
endmodule
`default_nettype wire

// ===== tb/reset_config_strap_latch_bench.sv
`timescale 1ns/10ps
`default_nettype none
module reset_config_strap_latch_bench;
	import strap_pkg::*;
	logic CLOCK, RST, SOFT_N, TCK, TMS, HARD_N, TEST_N, MC, TAPR, RX, VALID;
	logic probe_hard, board_hard, probe_test, tie_test;
	logic [1:0] ratio;
	logic [7:0] pd, FOUT, FOE, PAD, POUT, POE, PU, CFG, keep;
	int seed, miscompares, checked, pulses;
	reset_board_model u_reset_board_model (.probe_hard_n(probe_hard), .board_hard_n(board_hard),
		.probe_test_n(probe_test), .tie_test(tie_test), .pull_down(pd), .ratio(ratio), .pin_out(POUT),
		.pin_oe(POE), .pullup_en(PU), .hard_n(HARD_N), .test_n(TEST_N), .pad(PAD));
	strap_latch #(.HOLD(4)) u_strap_latch (.CLOCK(CLOCK), .RST(RST), .HARD_RESET_IN_N(HARD_N),
		.SOFT_RESET_IN_N(SOFT_N), .TEST_RESET_IN_N(TEST_N), .TCK(TCK), .TMS(TMS),
		.STRAP_PIN_IN(PAD), .FUNC_OUT(FOUT), .FUNC_OE(FOE), .STRAP_PIN_OUT(POUT),
		.STRAP_PIN_OE(POE), .PULLUP_EN(PU), .RECEIVER_EN(RX), .CONFIG_OUT(CFG),
		.CONFIG_VALID(VALID), .MACHINE_CHECK(MC), .TAP_RESET(TAPR));
	initial begin
		CLOCK = 0;
		forever #12.5 CLOCK = ~CLOCK;
	end
	// ============================================================
	// Checking helpers.
	function automatic logic [7:0] exp_cfg(input logic [7:0] d, input logic [1:0] r);
		return {~d[7:2], r};
	endfunction
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (e !== g) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge CLOCK);
	endtask
	task automatic tck_pulse;
		TCK = 1;
		cyc(4);
		TCK = 0;
		cyc(4);
	endtask
	task automatic close_out;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#50000;
		miscompares++;
		close_out;
	end
	// ============================================================
	// Main sequence.
	initial begin
		seed = 66; miscompares = 0; checked = 0;
		RST = 1; probe_hard = 0; board_hard = 1; probe_test = 1; tie_test = 1;
		SOFT_N = 1; TCK = 0; TMS = 0; pd = 8'h00; ratio = 2'b11; FOUT = 8'h00; FOE = 8'h00;
		cyc(8);
		RST = 0;
		for (int n = 0; n < 5; n++) begin
			if (n > 0) pd = 8'($random(seed));
			if (n == 4) pd = 8'hfc;
			ratio = 2'($random(seed));
			if (n == 0) ratio = 2'b11;
			FOUT = 8'($random(seed));
			FOE = 8'($random(seed));
			if (n % 2) board_hard = 0;
			else probe_hard = 0;
			cyc(5);
			chk("oe_in_reset", 8'h00, POE);
			chk("rx_in_reset", 8'h01, 8'(RX));
			chk("pu_in_reset", 8'hfc, PU);
			chk("tap_tied", 8'h01, 8'(TAPR));
			probe_hard = 1; board_hard = 1;
			cyc(5);
			chk("config", exp_cfg(pd, ratio), CFG);
			chk("valid", 8'h01, 8'(VALID));
			chk("rx_window", 8'h01, 8'(RX));
			chk("pu_window", 8'hfc, PU);
			keep = exp_cfg(pd, ratio);
			pd = ~pd;
			ratio = ~ratio;
			cyc(7);
			chk("rx_off", 8'h00, 8'(RX));
			chk("pu_off", 8'h00, PU);
			chk("oe_func", FOE, POE);
			chk("out_func", FOUT, POUT);
			chk("config_held", keep, CFG);
		end
		pulses = 0;
		SOFT_N = 0;
		for (int i = 0; i < 10; i++) begin
			cyc(1);
			if (MC === 1'b1) pulses++;
		end
		SOFT_N = 1;
		chk("mc_pulses", 8'h01, pulses[7:0]);
		chk("valid_soft", 8'h01, 8'(VALID));
		tie_test = 0;
		probe_test = 0;
		cyc(4);
		chk("tap_trst", 8'h01, 8'(TAPR));
		probe_test = 1;
		repeat (2) tck_pulse;
		chk("tap_idle", 8'h00, 8'(TAPR));
		TMS = 1;
		repeat (4) tck_pulse;
		chk("tap_four", 8'h00, 8'(TAPR));
		tck_pulse;
		chk("tap_tms", 8'h01, 8'(TAPR));
		close_out;
	end
endmodule
`default_nettype wire
